// ==== rtl/smbus_clk_cfg_defs.svh ====
// Shared offsets, reset values, field positions and timing counts
`ifndef SMBUS_CLK_CFG_DEFS_SVH
`define SMBUS_CLK_CFG_DEFS_SVH

// Own 7-bit bus address of the configuration slave
`define DEV_SLAVE_ADDR   7'h69
// Configuration byte offsets
`define OFF_FREQ         7'h00
`define OFF_SPREAD       7'h01
`define OFF_PERIPH       7'h02
// Reset values: sw code bit4 set, all clock enables on
`define RST_FREQ         8'h04
`define RST_SPREAD       8'h0F
`define RST_PERIPH       8'hFF
// Field positions
`define BYTE_OP_BIT      7
`define OVERRIDE_BIT     3
`define CODE4_BIT        2
`define CODE3_BIT        1
`define CODE2_BIT        6
`define CODE1_BIT        5
`define CODE0_BIT        4
`define SPREAD_HI        6
`define SPREAD_LO        4
`define CPU_HI           3
`define CPU_LO           1
`define INTR_BIT         0
// Bit counter values within a byte
`define LAST_DATA_CNT    4'h7
`define ACK_CNT          4'h8
// Link timing: quarter of a serial bit, least time, rounded up
`define REF_CLK_NS       100
`define QTR_NS           2500
`define QTR_CYC          ((`QTR_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)

`endif

// ==== rtl/smbus_clk_cfg_pkg.sv ====
// Types shared by both ends of the configuration link
package smbus_clk_cfg_pkg;

   typedef enum logic [3:0] {
      DS_IDLE      = 4'h0,
      DS_ADDR      = 4'h1,
      DS_ADDR_ACK  = 4'h2,
      DS_CMD       = 4'h3,
      DS_CMD_ACK   = 4'h4,
      DS_WDATA     = 4'h5,
      DS_WDATA_ACK = 4'h6,
      DS_RDATA     = 4'h7,
      DS_RDATA_ACK = 4'h8
   } dev_state_t;

   typedef enum logic [2:0] {
      SPREAD_OFF      = 3'h0,
      SPREAD_TEST     = 3'h1,
      SPREAD_RSVD     = 3'h2,
      SPREAD_TRISTATE = 3'h3,
      SPREAD_DN_050   = 3'h4,
      SPREAD_CTR_050  = 3'h5,
      SPREAD_CTR_025  = 3'h6,
      SPREAD_CTR_038  = 3'h7
   } spread_mode_t;

   typedef enum logic [1:0] {
      HS_IDLE  = 2'h0,
      HS_START = 2'h1,
      HS_BITS  = 2'h2,
      HS_STOP  = 2'h3
   } host_state_t;

   typedef enum logic [2:0] {
      PH_ADDR_W = 3'h0,
      PH_CMD    = 3'h1,
      PH_WDATA  = 3'h2,
      PH_ADDR_R = 3'h3,
      PH_RDATA  = 3'h4
   } host_phase_t;

endpackage

// ==== rtl/smbus_link_if.sv ====
// Two-wire open-drain link joining host and configuration slave
`timescale 1ns/1ps
`default_nettype none
interface smbus_link_if;
   logic host_scl_out;
   logic host_scl_oe;
   logic host_sda_out;
   logic host_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // Wired-AND with pull-up: any enabled low driver wins
   assign scl = ~(host_scl_oe & ~host_scl_out);
   assign sda = ~((host_sda_oe & ~host_sda_out)
                | (dev_sda_oe & ~dev_sda_out));

   modport host (
      output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe,
      input  scl, sda
   );
   modport device (
      output dev_sda_out, dev_sda_oe,
      input  scl, sda
   );
endinterface
`default_nettype wire

// ==== rtl/smbus_clk_cfg_slave.sv ====
// Configuration slave: byte read/write access to control bytes 0..2
`timescale 1ns/1ps
`default_nettype none
`include "smbus_clk_cfg_defs.svh"

module smbus_clk_cfg_slave
   import smbus_clk_cfg_pkg::*;
(
   input  wire logic         ref_clk_i,
   input  wire logic         srst_i,
   smbus_link_if.device      bus,
   input  wire logic [4:0]   hw_freq_select_pins_i,
   output logic              freq_source_sw_override_o,
   output logic [4:0]        sw_freq_code_o,
   output logic [4:0]        freq_code_o,
   output spread_mode_t      spread_mode_o,
   output logic [2:0]        cpu_clock_enable_o,
   output logic              intr_ctrl_clock_2_enable_o,
   output logic [7:0]        periph_bus_clock_enable_o
);

   // Three configuration bytes
   logic [7:0]  cfg [0:2];
   logic [7:0]  next_cfg [0:2];
   dev_state_t  state;
   dev_state_t  next_state;
   logic [3:0]  bit_cnt;
   logic [3:0]  next_bit_cnt;
   logic [7:0]  shreg;
   logic [7:0]  next_shreg;
   logic [6:0]  offset;
   logic [6:0]  next_offset;
   logic        rd_dir;
   logic        next_rd_dir;
   logic        sda_low;
   logic        next_sda_low;
   logic [4:0]  freq_code;
   logic [4:0]  next_freq_code;

   // Synchronisers for link wires and select pins
   logic        scl_s1;
   logic        scl_s2;
   logic        scl_d;
   logic        sda_s1;
   logic        sda_s2;
   logic        sda_d;
   logic [4:0]  pins_s1;
   logic [4:0]  pins_s2;

   logic        scl_rise;
   logic        scl_fall;
   logic        start_seen;
   logic        stop_seen;

   // Offsets beyond byte 2 are not held here
   function automatic logic mapped(input logic [6:0] off);
      mapped = (off <= `OFF_PERIPH);
   endfunction

   // Read data for an offset, zero when unmapped
   function automatic logic [7:0] rd_byte(input logic [6:0] off,
                                          input logic [7:0] b0,
                                          input logic [7:0] b1,
                                          input logic [7:0] b2);
      unique case (off)
         `OFF_FREQ:   rd_byte = b0;
         `OFF_SPREAD: rd_byte = b1;
         `OFF_PERIPH: rd_byte = b2;
         default:     rd_byte = 8'h00;
      endcase
   endfunction

   // Two flops before any logic looks at outside levels
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         scl_s1  <= 1'b1;
         scl_s2  <= 1'b1;
         scl_d   <= 1'b1;
         sda_s1  <= 1'b1;
         sda_s2  <= 1'b1;
         sda_d   <= 1'b1;
         pins_s1 <= 5'h00;
         pins_s2 <= 5'h00;
      end else begin
         scl_s1  <= bus.scl;
         scl_s2  <= scl_s1;
         scl_d   <= scl_s2;
         sda_s1  <= bus.sda;
         sda_s2  <= sda_s1;
         sda_d   <= sda_s2;
         pins_s1 <= hw_freq_select_pins_i;
         pins_s2 <= pins_s1;
      end
   end

   // Edge and bus-condition detection on the settled copies
   assign scl_rise   = scl_s2 & ~scl_d;
   assign scl_fall   = ~scl_s2 & scl_d;
   assign start_seen = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_seen  = scl_s2 & scl_d & ~sda_d & sda_s2;

   // Protocol engine and register writes
   always_comb begin
      next_state     = state;
      next_bit_cnt   = bit_cnt;
      next_shreg     = shreg;
      next_offset    = offset;
      next_rd_dir    = rd_dir;
      next_sda_low   = sda_low;
      next_cfg[0]    = cfg[0];
      next_cfg[1]    = cfg[1];
      next_cfg[2]    = cfg[2];
      if (start_seen) begin
         // Repeated start keeps the offset for the read
         next_state   = DS_ADDR;
         next_bit_cnt = 4'h0;
         next_sda_low = 1'b0;
      end else if (stop_seen) begin
         next_state   = DS_IDLE;
         next_sda_low = 1'b0;
      end else begin
         unique case (state)
            DS_IDLE: begin
               next_sda_low = 1'b0;
            end
            DS_ADDR, DS_CMD, DS_WDATA: begin
               if (scl_rise) begin
                  next_shreg   = {shreg[6:0], sda_s2};
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == `ACK_CNT) begin
                  next_sda_low = 1'b1;
                  if (state == DS_ADDR) begin
                     if (shreg[7:1] == `DEV_SLAVE_ADDR) begin
                        next_rd_dir = shreg[0];
                        next_state  = DS_ADDR_ACK;
                     end else begin
                        next_sda_low = 1'b0;
                        next_state   = DS_IDLE;
                     end
                  end else if (state == DS_CMD) begin
                     // byte op takes offset, else ignored
                     if (shreg[`BYTE_OP_BIT]) begin
                        next_offset = shreg[6:0];
                        next_state  = DS_CMD_ACK;
                     end else begin
                        next_sda_low = 1'b0;
                        next_state   = DS_IDLE;
                     end
                  end else begin
                     if (mapped(offset)) begin
                        next_cfg[offset[1:0]] = shreg;
                     end
                     next_offset = offset + 7'h01;
                     next_state  = DS_WDATA_ACK;
                  end
               end
            end
            DS_ADDR_ACK: begin
               if (scl_fall) begin
                  next_bit_cnt = 4'h0;
                  if (rd_dir) begin
                     // load byte, first bit on the wire
                     next_shreg   = rd_byte(offset, cfg[0], cfg[1], cfg[2]);
                     next_sda_low = ~next_shreg[7];
                     next_state   = DS_RDATA;
                  end else begin
                     next_sda_low = 1'b0;
                     next_state   = DS_CMD;
                  end
               end
            end
            DS_CMD_ACK, DS_WDATA_ACK: begin
               if (scl_fall) begin
                  next_sda_low = 1'b0;
                  next_bit_cnt = 4'h0;
                  next_state   = DS_WDATA;
               end
            end
            DS_RDATA: begin
               if (scl_rise) begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt == `ACK_CNT) begin
                     next_sda_low = 1'b0;
                     next_state   = DS_RDATA_ACK;
                  end else begin
                     next_shreg   = {shreg[6:0], 1'b0};
                     next_sda_low = ~shreg[6];
                  end
               end
            end
            DS_RDATA_ACK: begin
               if (scl_rise) begin
                  if (sda_s2) begin
                     next_state = DS_IDLE;
                  end else begin
                     next_offset = offset + 7'h01;
                     next_state  = DS_ADDR_ACK;
                  end
               end
            end
            default: begin
               next_state   = DS_IDLE;
               next_sda_low = 1'b0;
            end
         endcase
      end
      // override picks the soft code over the pins
      if (next_cfg[0][`OVERRIDE_BIT]) begin
         // soft code bits in documented order
         next_freq_code = {next_cfg[0][`CODE4_BIT], next_cfg[0][`CODE3_BIT],
                           next_cfg[0][`CODE2_BIT], next_cfg[0][`CODE1_BIT],
                           next_cfg[0][`CODE0_BIT]};
      end else begin
         next_freq_code = pins_s2;
      end
   end

   // Register the engine state
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state     <= DS_IDLE;
         bit_cnt   <= 4'h0;
         shreg     <= 8'h00;
         offset    <= 7'h00;
         rd_dir    <= 1'b0;
         sda_low   <= 1'b0;
         freq_code <= 5'h00;
         cfg[0]    <= `RST_FREQ;
         cfg[1]    <= `RST_SPREAD;
         cfg[2]    <= `RST_PERIPH;
      end else begin
         state     <= next_state;
         bit_cnt   <= next_bit_cnt;
         shreg     <= next_shreg;
         offset    <= next_offset;
         rd_dir    <= next_rd_dir;
         sda_low   <= next_sda_low;
         freq_code <= next_freq_code;
         cfg[0]    <= next_cfg[0];
         cfg[1]    <= next_cfg[1];
         cfg[2]    <= next_cfg[2];
      end
   end

   // Open drain: only ever pull low
   assign bus.dev_sda_out = 1'b0;
   assign bus.dev_sda_oe  = sda_low;

   // Outputs straight from flops: configuration bytes, and the freq_code register
   assign freq_source_sw_override_o = cfg[0][`OVERRIDE_BIT];
   assign sw_freq_code_o = {cfg[0][`CODE4_BIT], cfg[0][`CODE3_BIT],
                            cfg[0][`CODE2_BIT], cfg[0][`CODE1_BIT],
                            cfg[0][`CODE0_BIT]};
   assign freq_code_o    = freq_code;
   assign spread_mode_o  = spread_mode_t'(cfg[1][`SPREAD_HI:`SPREAD_LO]);
   assign cpu_clock_enable_o         = cfg[1][`CPU_HI:`CPU_LO];
   assign intr_ctrl_clock_2_enable_o = cfg[1][`INTR_BIT];
   assign periph_bus_clock_enable_o  = cfg[2];

endmodule
`default_nettype wire

// ==== rtl/smbus_clk_cfg_host.sv ====
// Host end: runs single byte-write and byte-read transactions
`timescale 1ns/1ps
`default_nettype none
`include "smbus_clk_cfg_defs.svh"
module smbus_clk_cfg_host
   import smbus_clk_cfg_pkg::*;
(
   input  wire logic         ref_clk_i,
   input  wire logic         srst_i,
   smbus_link_if.host        bus,
   input  wire logic         req_i,
   input  wire logic         read_i,
   input  wire logic [6:0]   slave_addr_i,
   input  wire logic [6:0]   offset_i,
   input  wire logic [7:0]   wdata_i,
   output logic              busy_o,
   output logic              done_o,
   output logic              nack_o,
   output logic [7:0]        rdata_o
);

   host_state_t state, next_state;
   host_phase_t phase, next_phase;
   logic [7:0]  tmr, next_tmr;
   logic [1:0]  qc, next_qc;
   logic [3:0]  bit_cnt, next_bit_cnt;
   logic [7:0]  tx, next_tx;
   logic [7:0]  rx, next_rx;
   logic [6:0]  addr, next_addr;
   logic [6:0]  off, next_off;
   logic [7:0]  wdat, next_wdat;
   logic        rd, next_rd;
   logic        scl_low, next_scl_low;
   logic        sda_low, next_sda_low;
   logic        got_nack, next_got_nack;
   logic        nack, next_nack;
   logic        done, next_done;
   logic [7:0]  rdata, next_rdata;
   logic        sda_s1;
   logic        sda_s2;
   logic        tick;

   // Line level from the wire passes two flops
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
      end else begin
         sda_s1 <= bus.sda;
         sda_s2 <= sda_s1;
      end
   end

   // Quarter-bit tick from the divider; no clock stretching honoured
   assign tick = (tmr == 8'(`QTR_CYC - 1));

   // Bit sequencer
   always_comb begin
      next_state    = state;
      next_phase    = phase;
      next_tmr      = 8'h00;
      next_qc       = qc;
      next_bit_cnt  = bit_cnt;
      next_tx       = tx;
      next_rx       = rx;
      next_addr     = addr;
      next_off      = off;
      next_wdat     = wdat;
      next_rd       = rd;
      next_scl_low  = scl_low;
      next_sda_low  = sda_low;
      next_got_nack = got_nack;
      next_nack     = nack;
      next_done     = 1'b0;
      next_rdata    = rdata;
      if (state == HS_IDLE) begin
         if (req_i) begin
            next_state = HS_START;
            next_phase = PH_ADDR_W;
            next_qc    = 2'h0;
            next_addr  = slave_addr_i;
            next_off   = offset_i;
            next_wdat  = wdata_i;
            next_rd    = read_i;
            next_nack  = 1'b0;
         end
      end else if (!tick) begin
         next_tmr = tmr + 8'h01;
      end else begin
         next_qc = qc + 2'h1;
         unique case (state)
            HS_START: begin
               // start or repeated start, then address
               unique case (qc)
                  2'h0: next_sda_low = 1'b0;
                  2'h1: next_scl_low = 1'b0;
                  2'h2: next_sda_low = 1'b1;
                  2'h3: begin
                     next_scl_low = 1'b1;
                     next_state   = HS_BITS;
                     next_bit_cnt = 4'h0;
                     // read bit only after the restart
                     next_tx = {addr, phase == PH_ADDR_R};
                  end
               endcase
            end
            HS_BITS: begin
               unique case (qc)
                  2'h0: next_sda_low = (bit_cnt <= `LAST_DATA_CNT)
                                       && (phase != PH_RDATA) && !tx[7];
                  2'h1: next_scl_low = 1'b0;
                  2'h2: begin
                     if (bit_cnt <= `LAST_DATA_CNT) begin
                        next_rx = {rx[6:0], sda_s2};
                        next_tx = {tx[6:0], 1'b0};
                     end else begin
                        next_got_nack = sda_s2;
                     end
                  end
                  2'h3: begin
                     next_scl_low = 1'b1;
                     next_bit_cnt = bit_cnt + 4'h1;
                     if (bit_cnt == `ACK_CNT) begin
                        if (phase == PH_RDATA) begin
                           next_rdata = rx;
                           next_state = HS_STOP;
                        end else if (got_nack) begin
                           next_nack  = 1'b1;
                           next_state = HS_STOP;
                        end else begin
                           unique case (phase)
                              PH_ADDR_W: begin
                                 next_phase   = PH_CMD;
                                 next_tx      = {1'b1, off};
                                 next_bit_cnt = 4'h0;
                              end
                              PH_CMD: begin
                                 next_bit_cnt = 4'h0;
                                 if (rd) begin
                                    next_phase = PH_ADDR_R;
                                    next_state = HS_START;
                                 end else begin
                                    next_phase = PH_WDATA;
                                    next_tx    = wdat;
                                 end
                              end
                              PH_ADDR_R: begin
                                 next_phase   = PH_RDATA;
                                 next_bit_cnt = 4'h0;
                              end
                              default: next_state = HS_STOP;
                           endcase
                        end
                     end
                  end
               endcase
            end
            HS_STOP: begin
               unique case (qc)
                  2'h0: next_sda_low = 1'b1;
                  2'h1: next_scl_low = 1'b0;
                  2'h2: next_sda_low = 1'b0;
                  2'h3: begin
                     next_done  = 1'b1;
                     next_state = HS_IDLE;
                  end
               endcase
            end
            default: next_state = HS_IDLE;
         endcase
      end
   end

   // Register sequencer state
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state    <= HS_IDLE;
         phase    <= PH_ADDR_W;
         tmr      <= 8'h00;
         qc       <= 2'h0;
         bit_cnt  <= 4'h0;
         tx       <= 8'h00;
         rx       <= 8'h00;
         addr     <= 7'h00;
         off      <= 7'h00;
         wdat     <= 8'h00;
         rd       <= 1'b0;
         scl_low  <= 1'b0;
         sda_low  <= 1'b0;
         got_nack <= 1'b0;
         nack     <= 1'b0;
         done     <= 1'b0;
         rdata    <= 8'h00;
      end else begin
         state    <= next_state;
         phase    <= next_phase;
         tmr      <= next_tmr;
         qc       <= next_qc;
         bit_cnt  <= next_bit_cnt;
         tx       <= next_tx;
         rx       <= next_rx;
         addr     <= next_addr;
         off      <= next_off;
         wdat     <= next_wdat;
         rd       <= next_rd;
         scl_low  <= next_scl_low;
         sda_low  <= next_sda_low;
         got_nack <= next_got_nack;
         nack     <= next_nack;
         done     <= next_done;
         rdata    <= next_rdata;
      end
   end

   // Open-drain drivers pull low only
   assign bus.host_scl_out = 1'b0;
   assign bus.host_scl_oe  = scl_low;
   assign bus.host_sda_out = 1'b0;
   assign bus.host_sda_oe  = sda_low;
   assign busy_o  = (state != HS_IDLE);
   assign done_o  = done;
   assign nack_o  = nack;
   assign rdata_o = rdata;

endmodule
`default_nettype wire

// ==== sim/smbus_clk_cfg_assertions.sv ====
// Wire-level checks on the link between host and slave
`timescale 1ns/1ps
`default_nettype none
module smbus_clk_cfg_assertions (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   // Slave quiet out of reset
   a_quiet_after_reset: assert property ($fell(srst_i) |-> !dev_sda_oe)
      else $error("slave drives data after reset");
   // Slave data only moves while the clock is low
   a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
      else $error("slave data moved with clock high");
   // Slave moves soon after the clock falls, not late in the low phase
   a_dev_change_late: assert property ($changed(dev_sda_oe) |-> $past(scl, 10))
      else $error("slave data moved late");
   // Driven bit is set up before the clock rises
   a_drive_setup: assert property ($rose(dev_sda_oe) |-> ##[1:60] $rose(scl))
      else $error("slave bit not followed by clock");
   // Slave bit held for 8 cycles after the clock rises
   a_drive_holds: assert property ($rose(scl) && dev_sda_oe |-> dev_sda_oe[*8])
      else $error("slave bit dropped while clock high");
   // Only the host makes a start
   a_start_by_host: assert property ($fell(sda) && scl |-> !dev_sda_oe)
      else $error("slave pulled data at start");
   // Stop leaves the slave idle
   a_stop_idle: assert property ($rose(sda) && scl |=> !dev_sda_oe[*8])
      else $error("slave drives after stop");
   // Clock low phase is not cut short
   a_scl_low_span: assert property ($fell(scl) |-> !scl[*8])
      else $error("clock low phase too short");
endmodule
`default_nettype wire

// ==== sim/smbus_clock_config_bank_tb.sv ====
// Bench: host and slave joined, byte accesses checked at both user sides
`timescale 1ns/1ps
`default_nettype none
`include "smbus_clk_cfg_defs.svh"
module smbus_clock_config_bank_tb;
   import smbus_clk_cfg_pkg::*;
   logic         ref_clk_i = 1'b0;
   logic         srst_i;
   logic         req_i, read_i, busy_o, done_o, nack_o, ovr;
   logic [6:0]   slave_addr_i, offset_i;
   logic [7:0]   wdata_i, rdata_o, periph;
   logic [4:0]   pins, sw_code, freq_code;
   spread_mode_t spread;
   logic [2:0]   cpu;
   logic         intr;
   int           mismatches = 0;
   int           checks = 0;

   // 10 MHz clock
   always #50 ref_clk_i = ~ref_clk_i;

   smbus_link_if link ();
   smbus_clk_cfg_host smbus_clk_cfg_host_inst (.ref_clk_i(ref_clk_i),
      .srst_i(srst_i), .bus(link), .req_i(req_i), .read_i(read_i),
      .slave_addr_i(slave_addr_i), .offset_i(offset_i), .wdata_i(wdata_i),
      .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o));
   smbus_clk_cfg_slave smbus_clk_cfg_slave_inst (.ref_clk_i(ref_clk_i),
      .srst_i(srst_i), .bus(link), .hw_freq_select_pins_i(pins),
      .freq_source_sw_override_o(ovr), .sw_freq_code_o(sw_code),
      .freq_code_o(freq_code), .spread_mode_o(spread),
      .cpu_clock_enable_o(cpu), .intr_ctrl_clock_2_enable_o(intr),
      .periph_bus_clock_enable_o(periph));
   smbus_clk_cfg_assertions chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
      .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      if (mismatches == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One byte transaction; bounded wait on done since a hang must end
   task automatic xfer(input logic rd, input logic [6:0] a,
                       input logic [6:0] o, input logic [7:0] d);
      int n = 0;
      @(posedge ref_clk_i);
      req_i <= 1'b1;
      read_i <= rd;
      slave_addr_i <= a;
      offset_i <= o;
      wdata_i <= d;
      @(posedge ref_clk_i);
      req_i <= 1'b0;
      do begin
         @(negedge ref_clk_i);
         n++;
      end while (done_o !== 1'b1 && n < 5000);
      if (n >= 5000) begin
         mismatches++;
         report_and_stop();
      end
      repeat (4) @(negedge ref_clk_i);
   endtask

   // Main sequence
   initial begin
      srst_i = 1'b1;
      req_i = 1'b0;
      read_i = 1'b0;
      slave_addr_i = 7'h00;
      offset_i = 7'h00;
      wdata_i = 8'h00;
      pins = 5'h15;
      repeat (10) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(negedge ref_clk_i);
      check({3'h0, sw_code}, 8'h10);
      check({4'h0, cpu, intr}, 8'h0F);
      check(periph, 8'hFF);
      xfer(1'b1, `DEV_SLAVE_ADDR, 7'h00, 8'h00);
      check(rdata_o, 8'h04);
      check({7'h00, nack_o}, 8'h00);
      check({3'h0, freq_code}, 8'h15);
      xfer(1'b0, `DEV_SLAVE_ADDR, 7'h00, 8'h7A);
      check({7'h00, busy_o}, 8'h00);
      check({7'h00, ovr}, 8'h01);
      check({3'h0, sw_code}, 8'h0F);
      check({3'h0, freq_code}, 8'h0F);
      // Pins must be ignored while the override is set
      pins <= 5'h0A;
      repeat (6) @(negedge ref_clk_i);
      check({3'h0, freq_code}, 8'h0F);
      // Every spread code, enables written as 4'hA alongside
      for (int m = 0; m < 8; m++) begin
         xfer(1'b0, `DEV_SLAVE_ADDR, 7'h01, {1'b0, 3'(m), 4'hA});
         check(8'(spread), 8'(m));
         check({4'h0, cpu, intr}, 8'h0A);
      end
      xfer(1'b1, `DEV_SLAVE_ADDR, 7'h01, 8'h00);
      check(rdata_o, 8'h7A);
      xfer(1'b0, `DEV_SLAVE_ADDR, 7'h02, 8'h5A);
      check(periph, 8'h5A);
      xfer(1'b1, `DEV_SLAVE_ADDR, 7'h02, 8'h00);
      check(rdata_o, 8'h5A);
      // Foreign address: refused, nothing stored
      xfer(1'b0, `DEV_SLAVE_ADDR ^ 7'h01, 7'h00, 8'h00);
      check({7'h00, nack_o}, 8'h01);
      xfer(1'b1, `DEV_SLAVE_ADDR, 7'h00, 8'h00);
      check(rdata_o, 8'h7A);
      // Unmapped offset: write dropped, read gives zero
      xfer(1'b0, `DEV_SLAVE_ADDR, 7'h03, 8'h3C);
      xfer(1'b1, `DEV_SLAVE_ADDR, 7'h03, 8'h00);
      check(rdata_o, 8'h00);
      // Override cleared: pins drive the code again
      xfer(1'b0, `DEV_SLAVE_ADDR, 7'h00, 8'h04);
      check({7'h00, ovr}, 8'h00);
      check({3'h0, freq_code}, 8'h0A);
      report_and_stop();
   end
endmodule
`default_nettype wire
